/* File: shared/rfam_pkg.sv */
// package: address map constants and carrier types for the register-file address map
package rfam_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PROG_AW = 12;
    localparam int REG_AW  = 8;
    // ------------------------------------------------------------
    // program memory map
    // ------------------------------------------------------------
    localparam logic [11:0] PROG_TOP        = 12'hFFF;
    localparam logic [11:0] VEC_TOP         = 12'h0FF;
    localparam logic [11:0] OPT_FIRST       = 12'h03C;
    localparam logic [11:0] OPT_LAST        = 12'h03F;
    localparam logic [11:0] OPT_CFG0        = 12'h03E;
    localparam logic [11:0] OPT_CFG1        = 12'h03F;
    localparam logic [11:0] RESET_ENTRY     = 12'h100;
    localparam logic [7:0]  OPT_ERASED      = 8'hFF;
    // ------------------------------------------------------------
    // register file map
    // ------------------------------------------------------------
    localparam logic [7:0] SET_BASE        = 8'hC0;
    localparam logic [7:0] SYS_BASE        = 8'hD0;
    localparam logic [7:0] CTRL_BASE       = 8'hE0;
    localparam logic [7:0] COMMON_LAST     = 8'hCF;
    localparam logic [7:0] PAGE_SEL_ADDR   = 8'hDF;
    localparam logic [7:0] FIRST_PTR_ADDR  = 8'hD6;
    localparam logic [7:0] SECOND_PTR_ADDR = 8'hD7;
    localparam logic [7:0] PAGE_SEL_RST    = 8'h00;
    localparam logic [7:0] FIRST_PTR_RST   = 8'hC0;
    localparam logic [7:0] SECOND_PTR_RST  = 8'hC8;
    localparam int         BANK_BIT        = 5;
    // ------------------------------------------------------------
    // apb register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] APB_CTRL    = 8'h00;
    localparam logic [7:0] APB_STATUS  = 8'h04;
    localparam logic [7:0] APB_PTRS    = 8'h08;
    localparam logic [7:0] APB_OPTIONS = 8'h0C;
    localparam logic [7:0] APB_BOOT    = 8'h10;
    localparam int         CTRL_BANK   = 0;
    // ------------------------------------------------------------
    // access types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_REG, MODE_WORK, MODE_IND, MODE_IDX} rfam_mode_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_PRIME, SEL_COMMON, SEL_SYS, SEL_CTRL0, SEL_CTRL1, SEL_SET2}
        rfam_sel_t;
    typedef struct packed {
        logic       valid;
        rfam_mode_t mode;
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } rfam_req_t;
    typedef struct packed {
        rfam_sel_t  sel;
        logic [7:0] addr;
        logic [3:0] page;
        logic       hi_byte;
    } rfam_res_t;
endpackage

/* File: core/rfam_addr_map.sv */
// module: program and register address decoding with pointer registers
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - program addresses are 12 bits; register bus carries 8-bit address and data
// - program memory decodes 000H through 0FFFH
// - 000H..0FFH vector area; 3CH..3FH are not ordinary program memory
// - after reset the fetch address is 0100H
// - start-up options read only from 003EH and 003FH
// - erased option value FFH enables low-voltage reset and internal RC
// - C0H..FFH is set 1, always reached by plain register mode
// - set 1 upper 32 bytes banked twice; lower 32 bytes unbanked
// - control at E0H..FFH, system at D0H..DFH, common area C0H..CFH
// - set 2 at C0H..FFH chosen only by indirect or indexed modes
// - 00H..BFH reachable by plain, indirect and indexed modes right after reset; working mode once a pointer is below C0H
// - page select at DFH holds source/destination nibbles, reset zero
// - no paging; every access resolves to page 0
// - reset sets slice pointers to C0H and C8H
// - slices are 8 bytes sharing five upper address bits
// - pointer-relative accesses never reach set 2
// - working address top bit picks pointer; pointer[7:3] joined with low three
// - slice pointers live at D6H and D7H, writable
// - register pair: even address holds high byte, odd holds low
module rfam_addr_map
    import rfam_pkg::*;
#(
    parameter int PAW = PROG_AW
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // cpu register request
    input  wire rfam_req_t        reg_req,
    output rfam_res_t             reg_res,
    output logic [7:0]            reg_rdata,
    // cpu program request
    input  wire logic             prog_valid,
    input  wire logic [PAW-1:0]   prog_addr,
    input  wire logic [7:0]       prog_rdata,
    output logic                  prog_hit,
    output logic                  prog_opt_cell,
    output logic [PAW-1:0]        fetch_addr,
    // start-up option cells
    input  wire logic [7:0]       opt_cell_a,
    input  wire logic [7:0]       opt_cell_b,
    output logic                  low_voltage_reset_detector_en,
    output logic                  internal_rc_sel
);
    if (PAW != 12) begin : g_paw_check
        $error("program address width must be 12");
    end

    // ------------------------------------------------------------
    // decode function
    // ------------------------------------------------------------
    function automatic rfam_sel_t decode_sel(input rfam_mode_t m, input logic [7:0] a, input logic bank);
        rfam_sel_t s;
        s = SEL_PRIME;
        if (a >= SET_BASE) begin
            if ((m == MODE_IND || m == MODE_IDX)) s = SEL_SET2;
            else if (a >= CTRL_BASE) s = bank ? SEL_CTRL1 : SEL_CTRL0;
            else if (a >= SYS_BASE) s = SEL_SYS;
            else s = SEL_COMMON;
        end
        return s;
    endfunction

    logic [7:0] first_slice_pointer_r;
    logic [7:0] second_slice_pointer_r;
    logic [7:0] page_select_pointer_r;
    logic [7:0] ctrl_r;
    logic [7:0] opt_a_r, opt_b_r;
    logic       boot_r;
    logic [7:0] eff_addr;
    rfam_sel_t  eff_sel;
    logic       reg_wr;

    // ------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------
    always_comb begin
        eff_addr = reg_req.addr;
        if (reg_req.mode == MODE_WORK) begin
            eff_addr = reg_req.addr[3] ? {second_slice_pointer_r[7:3], reg_req.addr[2:0]}
                                       : {first_slice_pointer_r[7:3], reg_req.addr[2:0]};
        end
        eff_sel = decode_sel(reg_req.mode, eff_addr, ctrl_r[CTRL_BANK]);
    end

    assign reg_wr = reg_req.valid && reg_req.wr && (eff_sel == SEL_SYS);

    // ------------------------------------------------------------
    // cpu-facing result
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_res   <= '0;
            reg_rdata <= 8'h00;
        end else begin
            reg_res.sel     <= reg_req.valid ? eff_sel : SEL_NONE;
            reg_res.addr    <= eff_addr;
            reg_res.page    <= 4'h0;
            reg_res.hi_byte <= ~eff_addr[0];
            case (eff_addr)
                FIRST_PTR_ADDR:  reg_rdata <= first_slice_pointer_r;
                SECOND_PTR_ADDR: reg_rdata <= second_slice_pointer_r;
                PAGE_SEL_ADDR:   reg_rdata <= page_select_pointer_r;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pointer registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_slice_pointer_r  <= FIRST_PTR_RST;
            second_slice_pointer_r <= SECOND_PTR_RST;
            page_select_pointer_r  <= PAGE_SEL_RST;
        end else if (reg_wr) begin
            if (eff_addr == FIRST_PTR_ADDR) first_slice_pointer_r <= reg_req.wdata;
            if (eff_addr == SECOND_PTR_ADDR) second_slice_pointer_r <= reg_req.wdata;
            if (eff_addr == PAGE_SEL_ADDR && !ctrl_r[CTRL_BANK])
                page_select_pointer_r <= reg_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // program side
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_hit      <= 1'b0;
            prog_opt_cell <= 1'b0;
            fetch_addr    <= '0;
            boot_r        <= 1'b1;
        end else begin
            boot_r        <= 1'b0;
            if (boot_r) fetch_addr <= RESET_ENTRY;
            else if (prog_valid) fetch_addr <= prog_addr;
            prog_hit      <= prog_valid && (prog_addr <= PROG_TOP);
            prog_opt_cell <= prog_valid && prog_addr >= OPT_FIRST && prog_addr <= OPT_LAST;
        end
    end

    // option cells taken after reset release only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_a_r                        <= OPT_ERASED;
            opt_b_r                        <= OPT_ERASED;
            low_voltage_reset_detector_en  <= 1'b1;
            internal_rc_sel                <= 1'b1;
        end else begin
            if (boot_r) begin
                opt_a_r <= opt_cell_a;
                opt_b_r <= opt_cell_b;
            end
            low_voltage_reset_detector_en <= (opt_a_r == OPT_ERASED);
            internal_rc_sel               <= (opt_b_r == OPT_ERASED);
        end
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= 8'h00;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    APB_CTRL:    prdata <= {24'h00_0000, ctrl_r};
                    APB_STATUS:  prdata <= {20'h0_0000, 1'b0, reg_res.sel, page_select_pointer_r};
                    APB_PTRS:    prdata <= {16'h0000, second_slice_pointer_r, first_slice_pointer_r};
                    APB_OPTIONS: prdata <= {16'h0000, opt_b_r, opt_a_r};
                    APB_BOOT:    prdata <= {20'h0_0000, fetch_addr};
                    default:     pslverr <= 1'b1;
                endcase
            end
            // write lands only at the completing access edge
            if (psel && penable && pready && pwrite && paddr == APB_CTRL) ctrl_r <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_boot;
        $rose(presetn) ##1 1'b1;
    endsequence

    sequence s_capture;
        $rose(presetn) ##2 1'b1;
    endsequence

    sequence s_work_req;
        reg_req.valid && reg_req.mode == MODE_WORK;
    endsequence

    chk_fetch_entry: assert property (@(posedge pclk)
        s_boot |=> fetch_addr == RESET_ENTRY)
        else $error("fetch address not reset entry");
    chk_set2_modes: assert property (@(posedge pclk) disable iff (!presetn)
        reg_res.sel == SEL_SET2 |-> $past(reg_req.mode) inside {MODE_IND, MODE_IDX})
        else $error("set 2 chosen by wrong mode");
    chk_prime_any_mode: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && eff_addr < SET_BASE |=> reg_res.sel == SEL_PRIME)
        else $error("prime area not selected");
    chk_work_no_set2: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_WORK |=> reg_res.sel != SEL_SET2)
        else $error("working access reached set 2");
    chk_work_concat: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_WORK && !reg_req.addr[3]
        |=> reg_res.addr == {$past(first_slice_pointer_r[7:3]), $past(reg_req.addr[2:0])})
        else $error("working address concat wrong");
    chk_page_zero: assert property (@(posedge pclk) disable iff (!presetn)
        reg_res.page == 4'h0)
        else $error("page not zero");
    chk_ptr_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> first_slice_pointer_r == FIRST_PTR_RST && second_slice_pointer_r == SECOND_PTR_RST)
        else $error("slice pointers wrong after reset");
    chk_ptr_write: assert property (@(posedge pclk) disable iff (!presetn)
        reg_wr && eff_addr == SECOND_PTR_ADDR |=> second_slice_pointer_r == $past(reg_req.wdata))
        else $error("second pointer write lost");
    chk_pair_order: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_REG |=> reg_res.hi_byte == !$past(reg_req.addr[0]))
        else $error("pair byte order wrong");
    chk_opt_cells: assert property (@(posedge pclk) disable iff (!presetn)
        prog_valid && prog_addr == OPT_CFG0 |=> prog_opt_cell && prog_hit)
        else $error("option cell not flagged");
    chk_bank_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_REG && reg_req.addr >= CTRL_BASE
        |=> reg_res.sel == ($past(ctrl_r[CTRL_BANK]) ? SEL_CTRL1 : SEL_CTRL0))
        else $error("bank select wrong");

    // ------------------------------------------------------------
    // register checks
    // ------------------------------------------------------------
    chk_ptr_first_write: assert property (@(posedge pclk) disable iff (!presetn)
        reg_wr && eff_addr == FIRST_PTR_ADDR |=> first_slice_pointer_r == $past(reg_req.wdata))
        else $error("first pointer write lost");
    chk_page_write: assert property (@(posedge pclk) disable iff (!presetn)
        reg_wr && eff_addr == PAGE_SEL_ADDR && !ctrl_r[CTRL_BANK] |=> page_select_pointer_r == $past(reg_req.wdata))
        else $error("page select write lost");
    chk_page_bank1: assert property (@(posedge pclk) disable iff (!presetn)
        reg_wr && eff_addr == PAGE_SEL_ADDR && ctrl_r[CTRL_BANK] |=> $stable(page_select_pointer_r))
        else $error("page select written from bank 1");
    chk_page_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> page_select_pointer_r == PAGE_SEL_RST)
        else $error("page select not cleared by reset");
    chk_sys_window: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_REG && reg_req.addr inside {[SYS_BASE:PAGE_SEL_ADDR]} |=> reg_res.sel == SEL_SYS)
        else $error("system window not selected");
    chk_common_work: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_WORK && eff_addr inside {[SET_BASE:COMMON_LAST]} |=> reg_res.sel == SEL_COMMON)
        else $error("common area not selected");
    chk_ctrl_upper: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode inside {MODE_REG, MODE_WORK} && eff_addr >= CTRL_BASE |=> reg_res.sel inside {SEL_CTRL0, SEL_CTRL1})
        else $error("control window not selected");
    chk_idle_none: assert property (@(posedge pclk) disable iff (!presetn)
        !reg_req.valid |=> reg_res.sel == SEL_NONE)
        else $error("select without request");
    chk_prime_sel_back: assert property (@(posedge pclk) disable iff (!presetn)
        reg_res.sel == SEL_PRIME |-> $past(eff_addr) < SET_BASE)
        else $error("prime select above prime area");
    chk_set1_plain: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_REG |=> reg_res.sel != SEL_SET2)
        else $error("plain mode reached set 2");
    chk_work_second: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.mode == MODE_WORK && reg_req.addr[3]
        |=> reg_res.addr == {$past(second_slice_pointer_r[7:3]), $past(reg_req.addr[2:0])})
        else $error("second slice concat wrong");
    chk_work_slice: assert property (@(posedge pclk) disable iff (!presetn)
        s_work_req |=> reg_res.addr[2:0] == $past(reg_req.addr[2:0]))
        else $error("slice offset lost");
    chk_wr_refused: assert property (@(posedge pclk) disable iff (!presetn)
        reg_req.valid && reg_req.wr && reg_req.mode inside {MODE_IND, MODE_IDX}
        |=> $stable(first_slice_pointer_r) && $stable(second_slice_pointer_r) && $stable(page_select_pointer_r))
        else $error("pointer written through set 2 mode");

    // ------------------------------------------------------------
    // program and option checks
    // ------------------------------------------------------------
    chk_opt_lvr: assert property (@(posedge pclk)
        s_capture |-> low_voltage_reset_detector_en == ($past(opt_cell_a, 2) == OPT_ERASED))
        else $error("low-voltage reset enable wrong");
    chk_opt_rc: assert property (@(posedge pclk)
        s_capture |-> internal_rc_sel == ($past(opt_cell_b, 2) == OPT_ERASED))
        else $error("oscillator select wrong");
    chk_prog_hit: assert property (@(posedge pclk) disable iff (!presetn)
        prog_valid |=> prog_hit)
        else $error("program address not decoded");
    chk_vec_plain: assert property (@(posedge pclk) disable iff (!presetn)
        prog_valid && !(prog_addr inside {[OPT_FIRST:OPT_LAST]}) |=> !prog_opt_cell)
        else $error("plain cell flagged as option");
    chk_fetch_follow: assert property (@(posedge pclk) disable iff (!presetn)
        prog_valid && !boot_r |=> fetch_addr == $past(prog_addr))
        else $error("fetch address not followed");
endmodule // rfam_addr_map

/* File: verif/rfam_cpu_model.sv */
// cpu core model issuing register and program requests
`timescale 1ns/1ps
module rfam_cpu_model
    import rfam_pkg::*;
(
    // clock
    input  wire logic   pclk,
    // requests toward the map
    output rfam_req_t   reg_req,
    output logic        prog_valid,
    output logic [11:0] prog_addr,
    output logic [7:0]  prog_rdata
);
    initial begin
        reg_req = '0;
        prog_valid = 1'b0;
        prog_addr = 12'h000;
        prog_rdata = 8'hFF;
    end
    // common area reached in working or plain register mode
    task automatic reg_op(input rfam_mode_t m, input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        reg_req <= '{valid: 1'b1, mode: m, addr: a, wr: w, wdata: d};
        @(posedge pclk);
        reg_req <= '{valid: 1'b0, mode: m, addr: ~a, wr: 1'b0, wdata: ~d};
        #1;
    endtask
    task automatic fetch(input logic [11:0] a);
        @(posedge pclk);
        prog_valid <= 1'b1;
        prog_addr <= a;
        prog_rdata <= a[7:0];
        @(posedge pclk);
        prog_valid <= 1'b0;
        prog_addr <= ~a;
        prog_rdata <= ~a[7:0];
        #1;
    endtask
endmodule // rfam_cpu_model

/* File: verif/rfam_addr_map_tb_top.sv */
// testbench for the register-file address map
`timescale 1ns/1ps
module register_file_address_map_tb_top
    import rfam_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, opt_cell_a = 8'hFF, opt_cell_b = 8'hFF;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, prog_valid, prog_hit, prog_opt_cell, lvr_en, rc_sel;
    rfam_req_t reg_req;
    rfam_res_t reg_res;
    logic [7:0] reg_rdata, prog_rdata;
    logic [11:0] prog_addr, fetch_addr;
    int n_errors = 0, tests_run = 0;
    always #2.5 pclk = ~pclk;
    rfam_cpu_model cpu (.pclk(pclk), .reg_req(reg_req), .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata));
    rfam_addr_map uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reg_req(reg_req), .reg_res(reg_res), .reg_rdata(reg_rdata), .prog_valid(prog_valid),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .prog_hit(prog_hit), .prog_opt_cell(prog_opt_cell),
        .fetch_addr(fetch_addr), .opt_cell_a(opt_cell_a), .opt_cell_b(opt_cell_b),
        .low_voltage_reset_detector_en(lvr_en), .internal_rc_sel(rc_sel));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: value %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chk_res(input rfam_sel_t s, input logic [7:0] a);
        rfam_res_t exp;
        exp = '{sel: s, addr: a, page: 4'h0, hi_byte: ~a[0]};
        tests_run++;
        if (reg_res !== exp) begin
            n_errors++;
            $display("unexpected at %0t: result %h, want %h", $time, reg_res, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk_val(32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rfam_mode_t md[3] = '{MODE_REG, MODE_IND, MODE_IDX};
        do_reset();
        chk_val(fetch_addr, 32'h100);
        chk_val({lvr_en, rc_sel}, 32'h3);
        apb(1'b0, APB_PTRS, 32'h0);
        chk_val(rd[15:0], 32'hC8C0);
        apb(1'b0, APB_STATUS, 32'h0);
        chk_val(rd[7:0], 32'h00);
        end_test("reset");
        cpu.reg_op(MODE_WORK, 8'h03, 1'b0, 8'h00);
        chk_res(SEL_COMMON, 8'hC3);
        cpu.reg_op(MODE_WORK, 8'h0C, 1'b0, 8'h00);
        chk_res(SEL_COMMON, 8'hCC);
        cpu.reg_op(MODE_REG, 8'hD6, 1'b1, 8'h80);
        cpu.reg_op(MODE_REG, 8'hD7, 1'b1, 8'hE8);
        cpu.reg_op(MODE_REG, 8'hD6, 1'b0, 8'h00);
        chk_val(reg_rdata, 32'h80);
        cpu.reg_op(MODE_WORK, 8'h05, 1'b0, 8'h00);
        chk_res(SEL_PRIME, 8'h85);
        cpu.reg_op(MODE_WORK, 8'h0A, 1'b0, 8'h00);
        chk_res(SEL_CTRL0, 8'hEA);
        apb(1'b0, APB_PTRS, 32'h0);
        chk_val(rd[15:0], 32'hE880);
        end_test("pointers");
        foreach (md[i]) begin
            cpu.reg_op(md[i], 8'h45, 1'b0, 8'h00);
            chk_res(SEL_PRIME, 8'h45);
        end
        cpu.reg_op(MODE_REG, 8'hDF, 1'b1, 8'h5A);
        cpu.reg_op(MODE_REG, 8'hDF, 1'b0, 8'h00);
        chk_val(reg_rdata, 32'h5A);
        cpu.reg_op(MODE_IND, 8'h30, 1'b0, 8'h00);
        chk_res(SEL_PRIME, 8'h30);
        cpu.reg_op(MODE_REG, 8'hE4, 1'b0, 8'h00);
        chk_res(SEL_CTRL0, 8'hE4);
        cpu.reg_op(MODE_IND, 8'hE4, 1'b0, 8'h00);
        chk_res(SEL_SET2, 8'hE4);
        cpu.reg_op(MODE_IDX, 8'hC0, 1'b0, 8'h00);
        chk_res(SEL_SET2, 8'hC0);
        cpu.reg_op(MODE_REG, 8'hD0, 1'b0, 8'h00);
        chk_res(SEL_SYS, 8'hD0);
        apb(1'b1, APB_CTRL, 32'h1);
        cpu.reg_op(MODE_REG, 8'hE4, 1'b0, 8'h00);
        chk_res(SEL_CTRL1, 8'hE4);
        cpu.reg_op(MODE_REG, 8'hD1, 1'b0, 8'h00);
        chk_res(SEL_SYS, 8'hD1);
        apb(1'b0, 8'h20, 32'h0);
        chk_val(err, 32'h1);
        end_test("decode");
        for (int a = 12'h03B; a <= 12'h040; a++) begin
            cpu.fetch(a[11:0]);
            chk_val({prog_hit, prog_opt_cell}, {30'h0, 1'b1, a >= 12'h03C && a <= 12'h03F});
        end
        cpu.fetch(PROG_TOP);
        chk_val(prog_hit, 32'h1);
        apb(1'b0, APB_BOOT, 32'h0);
        chk_val(rd[11:0], 32'hFFF);
        end_test("program");
        opt_cell_b <= 8'hFE;
        do_reset();
        chk_val({lvr_en, rc_sel}, 32'h2);
        apb(1'b0, APB_OPTIONS, 32'h0);
        chk_val(rd[15:0], 32'hFEFF);
        end_test("options");
        tally_and_finish();
    end
endmodule // register_file_address_map_tb_top
